/* hw/spd_params.svh */
// constants for the serial presence detect eeprom slave
// assumes a 100 MHz hclk and an AHB-Lite master with 32-bit data
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

`define SPD_TYPE_MEM        4'hA
`define SPD_TYPE_PROT       4'h6
`define SPD_CHIP_SWP        3'h1
`define SPD_CHIP_CWP        3'h3
`define SPD_BYTE_LAST       4'h8
// bit count when a stop lands in the slot right after a data ack
`define SPD_SLOT_STOP       4'h1
`define SPD_PAGE_BYTES      16
`define SPD_MEM_BYTES       256
`define SPD_CLK_PERIOD_NS   10
`define SPD_PROG_TIME_NS    5000
`define SPD_REG_CTRL        8'h00
`define SPD_REG_STATUS      8'h04
`define SPD_CTRL_EN_BIT     0
`define SPD_CTRL_RESET      1'b1
`define SPD_ST_BUSY_BIT     0
`define SPD_ST_SWP_BIT      1
`define SPD_ST_PERM_BIT     2
`define SPD_ST_ADDR_LSB     8
`define SPD_SWP_RESET       1'b0
`define SPD_PERM_RESET      1'b0

`endif

/* hw/spd_pkg.sv */
// types shared by the serial presence detect eeprom slave
// assumes nothing beyond the constants header
package spd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_PROG
    } spd_state_type;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_MEM,
        CMD_SWP,
        CMD_CWP,
        CMD_PERMANENT_PROTECT_CMD
    } spd_cmd_type;
endpackage

/* hw/spd_eeprom_slave.sv */
// serial eeprom slave: two-wire command logic, array, protection, AHB regs
// assumes scl and sda arrive from pins, sda is resolved outside from oe
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`include "spd_params.svh"
`timescale 1ns/10ps
`default_nettype none

module spd_eeprom_slave #(
    parameter int PROG_TIME_NS  = `SPD_PROG_TIME_NS,
    parameter int CLK_PERIOD_NS = `SPD_CLK_PERIOD_NS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        strap_addr_bit0,
    input  wire logic        strap_addr_bit1,
    input  wire logic        strap_addr_bit2,
    input  wire logic        write_inhibit_in,
    input  wire logic        high_voltage_level
);
    localparam int PROG_RAW    = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_RAW < `SPD_PAGE_BYTES) ?
                                 `SPD_PAGE_BYTES : PROG_RAW;
    localparam int PCW         = $clog2(PROG_CYCLES + 1);
    localparam int NSYNC       = 7;

    // pin synchronisers
    logic [NSYNC-1:0] sync_m_r;
    logic [NSYNC-1:0] sync_s_r;
    logic             scl_p_r;
    logic             sda_p_r;
    logic             scl_s;
    logic             sda_s;
    logic             wi_s;
    logic             hv_s;
    logic [2:0]       straps;

    spd_pkg::spd_state_type st_r;
    spd_pkg::spd_cmd_type   cmd_r;
    spd_pkg::spd_cmd_type   cmd_dec;
    logic [3:0]             bitcnt_r;
    logic [7:0]             sh_r;
    logic [7:0]             out_r;
    logic [7:0]             addr_r;
    logic                   data_seen_r;
    logic                   pend_r;
    logic [15:0]            pval_r;
    logic [7:0]             pbuf [`SPD_PAGE_BYTES];
    logic [7:0]             mem [`SPD_MEM_BYTES];
    logic [PCW-1:0]         pcnt_r;
    logic                   swp_r;
    logic                   perm_r;
    logic                   link_en_r;
    logic                   dph_r;
    logic                   wr_r;
    logic [7:0]             a_r;
    logic [31:0]            rd_val;

    logic rise;
    logic fall;
    logic start_cond;
    logic stop_cond;
    logic mem_hit;
    logic prot_hit;
    logic wr_block;
    logic [3:0] pidx;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // bus pins idle high, so no false edge follows reset
            sync_m_r <= '1;
            sync_s_r <= '1;
            scl_p_r  <= 1'b1;
            sda_p_r  <= 1'b1;
        end else if (ce) begin
            sync_m_r <= {scl_in, sda_in, write_inhibit_in, high_voltage_level,
                         strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            sync_s_r <= sync_m_r;
            scl_p_r  <= scl_s;
            sda_p_r  <= sda_s;
        end
    end

    assign scl_s  = sync_s_r[6];
    assign sda_s  = sync_s_r[5];
    assign wi_s   = sync_s_r[4];
    assign hv_s   = sync_s_r[3];
    assign straps = sync_s_r[2:0];

    assign rise       = scl_s & ~scl_p_r;
    assign fall       = ~scl_s & scl_p_r;
    assign start_cond = scl_s & scl_p_r & sda_p_r & ~sda_s;
    assign stop_cond  = scl_s & scl_p_r & ~sda_p_r & sda_s;

    // select byte decode
    assign mem_hit  = (sh_r[7:4] == `SPD_TYPE_MEM)
                      && (sh_r[3:1] == straps);
    assign prot_hit = (sh_r[7:4] == `SPD_TYPE_PROT) && !perm_r
                      && !sh_r[0];

    always_comb begin
        cmd_dec = spd_pkg::CMD_NONE;
        if (hv_s) begin
            // voltage on strap zero plus the level pattern on the others
            if (sh_r[3:1] == `SPD_CHIP_SWP && straps[2:1] == sh_r[3:2])
                cmd_dec = spd_pkg::CMD_SWP;
            else if (sh_r[3:1] == `SPD_CHIP_CWP && straps[2:1] == sh_r[3:2])
                cmd_dec = spd_pkg::CMD_CWP;
        end else if (sh_r[3:1] == straps) begin
            cmd_dec = spd_pkg::CMD_PERMANENT_PROTECT_CMD;
        end
    end

    // inhibit blocks all, protection blocks lower half
    assign wr_block = wi_s
                      | (~addr_r[7] & (swp_r | perm_r));

    assign pidx = pcnt_r[3:0];

    // two-wire protocol engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= spd_pkg::ST_IDLE;
            cmd_r       <= spd_pkg::CMD_NONE;
            bitcnt_r    <= '0;
            sh_r        <= '0;
            out_r       <= '0;
            addr_r      <= '0;
            data_seen_r <= 1'b0;
            pend_r      <= 1'b0;
            pval_r      <= '0;
            pcnt_r      <= '0;
            sda_oe      <= 1'b0;
            sda_out     <= 1'b0;
        end else if (ce) begin
            if (st_r == spd_pkg::ST_PROG) begin
                // bus is not looked at until the cycle ends
                sda_oe <= 1'b0;
                if (pcnt_r == '0)
                    st_r <= spd_pkg::ST_IDLE;
                else
                    pcnt_r <= pcnt_r - 1'b1;
            end else if (!link_en_r) begin
                st_r   <= spd_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                st_r        <= spd_pkg::ST_DEV;
                bitcnt_r    <= '0;
                sda_oe      <= 1'b0;
                data_seen_r <= 1'b0;
                pend_r      <= 1'b0;
                pval_r      <= '0;
            end else if (stop_cond) begin
                sda_oe <= 1'b0;
                // the stop's own scl rise has already counted one bit
                if (st_r == spd_pkg::ST_WDATA
                        && bitcnt_r == `SPD_SLOT_STOP
                        && data_seen_r && pend_r) begin
                    st_r   <= spd_pkg::ST_PROG;
                    pcnt_r <= PCW'(PROG_CYCLES - 1);
                end else begin
                    st_r <= spd_pkg::ST_IDLE;
                end
            end else if (st_r != spd_pkg::ST_IDLE) begin
                if (rise) begin
                    if (bitcnt_r == `SPD_BYTE_LAST) begin
                        bitcnt_r <= '0;
                        // ninth slot of a read byte, bus released by us
                        if (st_r == spd_pkg::ST_RDATA && !sda_oe) begin
                            if (sda_s) begin
                                st_r <= spd_pkg::ST_IDLE;
                            end else begin
                                out_r  <= mem[addr_r];
                                addr_r <= addr_r + 1'b1;
                            end
                        end
                    end else begin
                        sh_r     <= {sh_r[6:0], sda_s};
                        bitcnt_r <= bitcnt_r + 1'b1;
                    end
                end else if (fall) begin
                    if (bitcnt_r == `SPD_BYTE_LAST) begin
                        unique case (st_r)
                            spd_pkg::ST_DEV: begin
                                if (mem_hit) begin
                                    cmd_r  <= spd_pkg::CMD_MEM;
                                    sda_oe <= 1'b1;
                                    if (sh_r[0]) begin
                                        st_r   <= spd_pkg::ST_RDATA;
                                        out_r  <= mem[addr_r];
                                        addr_r <= addr_r + 1'b1;
                                    end else begin
                                        st_r <= spd_pkg::ST_ADDR;
                                    end
                                end else if (prot_hit
                                        && cmd_dec != spd_pkg::CMD_NONE) begin
                                    cmd_r  <= cmd_dec;
                                    sda_oe <= 1'b1;
                                    st_r   <= spd_pkg::ST_ADDR;
                                end else begin
                                    st_r <= spd_pkg::ST_IDLE;
                                end
                            end
                            spd_pkg::ST_ADDR: begin
                                if (cmd_r == spd_pkg::CMD_MEM)
                                    addr_r <= sh_r;
                                sda_oe <= 1'b1;
                                st_r   <= spd_pkg::ST_WDATA;
                            end
                            spd_pkg::ST_WDATA: begin
                                data_seen_r <= 1'b1;
                                if (cmd_r == spd_pkg::CMD_MEM) begin
                                    if (!wr_block) begin
                                        pbuf[addr_r[3:0]]   <= sh_r;
                                        pval_r[addr_r[3:0]] <= 1'b1;
                                        sda_oe              <= 1'b1;
                                        pend_r              <= 1'b1;
                                    end
                                    addr_r[3:0] <= addr_r[3:0] + 1'b1;
                                end else if (!wi_s) begin
                                    sda_oe <= 1'b1;
                                    pend_r <= 1'b1;
                                end
                            end
                            spd_pkg::ST_RDATA: sda_oe <= 1'b0;
                            spd_pkg::ST_IDLE,
                            spd_pkg::ST_PROG: sda_oe <= 1'b0;
                        endcase
                    end else if (st_r == spd_pkg::ST_RDATA) begin
                        sda_oe <= ~out_r[7];
                        out_r  <= {out_r[6:0], 1'b1};
                    end else begin
                        sda_oe <= 1'b0;
                    end
                end
            end
        end
    end

    // array update, one page entry per cycle in the last 16 cycles of the programming count
    always_ff @(posedge hclk) begin
        if (ce && st_r == spd_pkg::ST_PROG && cmd_r == spd_pkg::CMD_MEM
                && pcnt_r < PCW'(`SPD_PAGE_BYTES) && pval_r[pidx])
            mem[{addr_r[7:4], pidx}] <= pbuf[pidx];
    end

    // protection state, changed only at the end of a programming cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swp_r  <= `SPD_SWP_RESET;
            perm_r <= `SPD_PERM_RESET;
        end else if (ce && st_r == spd_pkg::ST_PROG && pcnt_r == '0) begin
            unique case (cmd_r)
                spd_pkg::CMD_SWP:  swp_r  <= 1'b1;
                spd_pkg::CMD_CWP:  swp_r  <= 1'b0;
                spd_pkg::CMD_PERMANENT_PROTECT_CMD: perm_r <= 1'b1;
                spd_pkg::CMD_NONE,
                spd_pkg::CMD_MEM: ;
            endcase
        end
    end

    // AHB-Lite slave, one wait state on every transfer
    always_comb begin
        rd_val = '0;
        if (a_r == `SPD_REG_CTRL) begin
            rd_val[`SPD_CTRL_EN_BIT] = link_en_r;
        end else if (a_r == `SPD_REG_STATUS) begin
            rd_val[`SPD_ST_BUSY_BIT] = (st_r == spd_pkg::ST_PROG);
            rd_val[`SPD_ST_SWP_BIT]  = swp_r;
            rd_val[`SPD_ST_PERM_BIT] = perm_r;
            rd_val[`SPD_ST_ADDR_LSB +: 8] = addr_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
            dph_r     <= 1'b0;
            wr_r      <= 1'b0;
            a_r       <= '0;
            link_en_r <= `SPD_CTRL_RESET;
        end else if (ce) begin
            if (dph_r) begin
                dph_r     <= 1'b0;
                hreadyout <= 1'b1;
                if (wr_r) begin
                    if (a_r == `SPD_REG_CTRL)
                        link_en_r <= hwdata[`SPD_CTRL_EN_BIT];
                end else begin
                    hrdata <= rd_val;
                end
            end else if (hsel && htrans[1] && hready) begin
                dph_r     <= 1'b1;
                hreadyout <= 1'b0;
                wr_r      <= hwrite;
                a_r       <= haddr[7:0];
            end
        end
    end
endmodule

`default_nettype wire

/* tb/spd_eeprom_slave_monitor.sv */
// port checker for the serial eeprom slave, attached by bind
// assumes one hclk domain with asynchronous active-low hresetn
`timescale 1ns/10ps
`default_nettype none
module spd_eeprom_slave_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    logic [3:0] bits_r;
    logic       req_r;
    // scl rises seen since the last start on the pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bits_r <= 4'h0;
        end else if (scl_in && $fell(sda_in)) begin
            bits_r <= 4'h0;
        end else if ($rose(scl_in) && bits_r != 4'hF) begin
            bits_r <= bits_r + 4'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= 1'h0;
        end else begin
            req_r <= hsel && htrans[1] && hready && ce;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("hresp not okay");
    a_wait_one: assert property (!hreadyout && ce |=> hreadyout)
        else $error("wait state too long");
    a_wait_cause: assert property (!hreadyout |-> req_r)
        else $error("wait state without request");
    a_rdata_hold: assert property ($changed(hrdata) |->
        hreadyout && !$past(hreadyout)) else $error("hrdata moved");
    a_open_drain: assert property (sda_out == 1'h0)
        else $error("sda driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) |->
        !scl_in && !$past(scl_in, 2)) else $error("sda moved, scl high");
    a_select_quiet: assert property ($rose(sda_oe) |->
        bits_r >= 4'h8) else $error("drive inside select byte");
    a_stop_quiet: assert property (scl_in && $rose(sda_in) |->
        !sda_oe [*8]) else $error("drive after stop");
endmodule
bind spd_eeprom_slave spd_eeprom_slave_monitor mon (.hclk(hclk),
    .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

/* tb/spd_bus_master_model.sv */
// two-wire bus master model driving scl, 160 ns bit period
// assumes sda is resolved outside with a pull-up
`timescale 1ns/10ps
`default_nettype none
module spd_bus_master_model (
    output logic     scl,
    output logic     sda_drv,
    input wire logic sda
);
    // scl stands high between frames
    initial begin
        scl = 1'h1;
        sda_drv = 1'h1;
    end
    task automatic put_bit(input logic b);
        #10 sda_drv = b;
        #70 scl = 1'h1;
        #80 scl = 1'h0;
    endtask
    task automatic get_bit(output logic b);
        #10 sda_drv = 1'h1;
        #70 scl = 1'h1;
        #40 b = sda;
        #40 scl = 1'h0;
    endtask
    task automatic start();
        // move pin changes off the bench clock's rising edges
        if ($time % 10 != 0) #(10 - $time % 10);
        #10 sda_drv = 1'h1;
        #70 scl = 1'h1;
        #40 sda_drv = 1'h0;
        #40 scl = 1'h0;
    endtask
    task automatic stop();
        #10 sda_drv = 1'h0;
        #70 scl = 1'h1;
        #40 sda_drv = 1'h1;
        #40;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask
    // more high acknowledges the byte, low ends the read
    task automatic recv(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(~more);
    endtask
endmodule
`default_nettype wire

/* tb/spd_eeprom_slave_tb.sv */
// self-checking bench for the serial eeprom slave
// assumes the bound port checker and the bus master model
`timescale 1ns/10ps
`default_nettype none
module spd_eeprom_slave_tb;
    logic        hclk, hresetn, hsel, hwrite, scl, m_sda, sda_oe;
    logic        sda_out, hreadyout, hresp, wi, hv, a0, a1, a2, a3, a4;
    logic [1:0]  htrans;
    logic [2:0]  straps, acks;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [7:0]  q [2];
    int          errors, samples_checked, polls;
    int          cycles = 0;
    wire         sda;
    assign sda = m_sda & ~sda_oe;
    spd_eeprom_slave #(.PROG_TIME_NS(2000)) uut (.hclk(hclk),
        .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap_addr_bit0(straps[0]),
        .strap_addr_bit1(straps[1]), .strap_addr_bit2(straps[2]),
        .write_inhibit_in(wi), .high_voltage_level(hv));
    spd_bus_master_model m (.scl(scl), .sda_drv(m_sda), .sda(sda));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask
    task automatic wr(input logic [3:0] t, input logic [7:0] a, input logic [7:0] d);
        m.start();
        m.send({t, straps, 1'h0}, acks[2]);
        m.send(a, acks[1]);
        m.send(d, acks[0]);
        m.stop();
    endtask
    // polls until ready, then dummy write and read of n bytes
    task automatic rd(input logic [7:0] a, input int n);
        polls = 0;
        do begin
            m.start();
            m.send({4'hA, straps, 1'h0}, a0);
            polls++;
        end while (!a0 && polls < 20);
        m.send(a, a0);
        m.start();
        m.send({4'hA, straps, 1'h1}, a0);
        chk(32'h1, 32'(a0));
        for (int i = 0; i < n; i++) m.recv(i < n - 1, q[i]);
        m.stop();
    endtask
    task automatic s_regs();
        ahb(1'h0, 32'h0, 32'h0);
        chk(32'h1, r);
        ahb(1'h0, 32'h4, 32'h0);
        chk(32'h0, r & 32'h7);
        ahb(1'h0, 32'h10, 32'h0);
        chk(32'h0, r);
    endtask
    task automatic s_select();
        for (int k = 0; k < 9; k++) begin
            m.start();
            m.send(k < 8 ? {4'hA, k[2:0], 1'h0} : {4'h5, straps, 1'h0}, a0);
            chk(32'(k < 8 && k == straps), 32'(a0));
            m.stop();
        end
        ahb(1'h1, 32'h0, 32'h0);
        m.start();
        m.send({4'hA, straps, 1'h1}, a0);
        m.stop();
        chk(32'h0, 32'(a0));
        ahb(1'h1, 32'h0, 32'h1);
    endtask
    task automatic s_write_read();
        m.start();
        m.send({4'hA, straps, 1'h0}, a0);
        m.send(8'h3E, a1);
        m.send(8'h11, a2);
        m.send(8'h22, a3);
        m.send(8'h33, a4);
        m.stop();
        chk(32'h1F, {27'h0, a0, a1, a2, a3, a4});
        ahb(1'h0, 32'h4, 32'h0);
        chk(32'h1, 32'(r[0]));
        rd(8'h30, 1);
        chk(32'h1, 32'(polls > 1));
        chk(32'h33, 32'(q[0]));
        rd(8'h3E, 1);
        chk(32'h11, 32'(q[0]));
        m.start();
        m.send({4'hA, straps, 1'h1}, a0);
        m.recv(1'h0, q[0]);
        m.stop();
        chk(32'h22, 32'(q[0]));
        m.start();
        m.send({4'hA, straps, 1'h0}, a0);
        m.send(8'h50, a0);
        m.stop();
        ahb(1'h0, 32'h4, 32'h0);
        chk(32'h0, 32'(r[0]));
        wr(4'hA, 8'hFF, 8'hA5);
        rd(8'hFF, 1);
        wr(4'hA, 8'h00, 8'h5A);
        rd(8'hFF, 2);
        chk(32'hA55A, {16'h0, q[0], q[1]});
    endtask
    task automatic s_protect();
        wr(4'hA, 8'h10, 8'hC3);
        @(posedge hclk);
        hv <= 1'h1;
        rd(8'h10, 1);
        wr(4'h6, 8'h00, 8'h00);
        chk(32'h7, 32'(acks));
        rd(8'h10, 1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(32'h2, r & 32'h7);
        wr(4'hA, 8'h10, 8'h99);
        chk(32'h6, 32'(acks));
        wr(4'hA, 8'h90, 8'h66);
        chk(32'h7, 32'(acks));
        rd(8'h10, 1);
        chk(32'hC3, 32'(q[0]));
        wi <= 1'h1;
        wr(4'hA, 8'h90, 8'h55);
        chk(32'h6, 32'(acks));
        wi <= 1'h0;
        rd(8'h90, 1);
        chk(32'h66, 32'(q[0]));
        straps <= 3'h3;
        wr(4'h6, 8'h00, 8'h00);
        chk(32'h7, 32'(acks));
        rd(8'h10, 1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(32'h0, r & 32'h7);
        straps <= 3'h1;
        hv <= 1'h0;
        wr(4'h6, 8'h00, 8'h00);
        rd(8'h10, 1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(32'h1, 32'(r[2]));
        wr(4'h6, 8'h00, 8'h00);
        chk(32'h0, 32'(acks));
        wr(4'hA, 8'h10, 8'h99);
        chk(32'h6, 32'(acks));
    endtask
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        wi = 1'h0;
        hv = 1'h0;
        straps = 3'h1;
        errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        s_regs();
        s_select();
        s_write_read();
        s_protect();
        wrap_up();
    end
endmodule
`default_nettype wire
